// File: src/fault_annunciator_reset_logic.sv
// fault annunciator and reset logic of the generator controller
// assumes sensor, switch and remote inputs are asynchronous pins; config and
// message-edit inputs come from logic on ref_clk_in
//
// Summary of operation
// RL1 - warning present lights amber lamp and message
// RL2 - panel reset clears corrected warnings, engine running
// RL3 - in auto, remote reset cycle clears warnings
// RL4 - shutdowns latch with red lamp until reset
// RL5 - panel reset clears shutdowns only in off
// RL6 - auto: drop remote start, then cycle reset
// RL7 - emergency stop cleared only from front panel
// RL8 - no standby while any fault stays latched
// RL9 - non-automatic lamp flashes while selector off
// RL10 - shutdown stops engine and closes breaker trip
// RL11 - display is two lines of sixteen characters
// RL12 - low oil pressure codes 200 and 201
// RL13 - coolant temperature codes 210 to 213
// RL14 - start and speed shutdowns 220, 221, 223
// RL15 - battery warnings 230, 231, 232
// RL16 - memory errors 250 shutdown, 251-252 warning
// RL17 - codes 261-263 configurable severity, editable text
// RL18 - 301, 303, 313, 335 electrical shutdowns
// RL19 - 320, 330 warnings; 321, 322 shutdowns
// RL20 - invalid setup or calibration: message only
// RL21 - low fuel codes 240 and 241
// RL22 - coolant level 214, 215; rack 260
// RL23 - remote reset cycle is assert then release
// RL24 - shutdown messages shown ahead of warnings
`timescale 1ns/1ps
`include "fault_annunciator_regs.svh"

module fault_annunciator_reset_logic
  import fault_annunciator_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = `FA_FLASH_HALF_MS * `FA_CLK_KHZ
) (
  input logic ref_clk_in,
  input logic reset_n_in,
  input logic [31:0] cond_in,
  input logic bad_setup_in,
  input logic bad_cal_in,
  input logic panel_reset_in,
  input logic remote_reset_in,
  input logic remote_start_in,
  input logic sel_run_in,
  input logic sel_auto_in,
  input logic [2:0] cust_sd_in,
  input logic msg_wr_in,
  input logic [1:0] msg_slot_in,
  input logic [3:0] msg_pos_in,
  input logic [7:0] msg_char_in,
  input logic standby_req_in,
  output logic warn_lamp_out,
  output logic sd_lamp_out,
  output logic not_auto_lamp_out,
  output logic engine_stop_out,
  output logic breaker_trip_out,
  output logic standby_grant_out,
  output logic disp_valid_out,
  output logic [11:0] disp_code_out,
  output logic [127:0] disp_line1_out,
  output logic [127:0] disp_line2_out
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 39;
  logic [SYNC_W-1:0] sync1_ff; // first stage, read only by sync2_ff
  logic [SYNC_W-1:0] sync2_ff; // settled copies of the pins
  logic [31:0] cond_s;
  logic setup_s, cal_s, press_s, rr_s, rstart_s, run_s, auto_s;
  logic press_d_ff; // last panel reset level, for edge detect
  logic rr_d_ff; // last remote reset level
  selector_t sel;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      press_d_ff <= 1'b0;
      rr_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {cond_in, bad_setup_in, bad_cal_in, panel_reset_in, remote_reset_in,
                   remote_start_in, sel_run_in, sel_auto_in};
      sync2_ff <= sync1_ff;
      press_d_ff <= press_s;
      rr_d_ff <= rr_s;
    end
  end

  assign {cond_s, setup_s, cal_s, press_s, rr_s, rstart_s, run_s, auto_s} = sync2_ff;
  // run wins if a broken switch shows both positions
  assign sel = run_s ? SEL_RUN : (auto_s ? SEL_AUTO : SEL_OFF);

  logic panel_press; // one pulse per press of the reset switch
  assign panel_press = press_s & ~press_d_ff;

  // ----------------------------------------------------------------
  // remote reset cycle tracker
  // ----------------------------------------------------------------
  rr_state_t rr_state_ff, nxt_rr_state;
  logic rem_warn_clr; // completed cycle in auto
  logic rem_sd_clr; // completed cycle with remote start removed first

  // only auto arms the tracker; leaving auto mid-cycle forfeits the cycle
  always_comb begin
    nxt_rr_state = rr_state_ff;
    rem_warn_clr = 1'b0;
    rem_sd_clr = 1'b0;
    if (sel != SEL_AUTO) begin
      nxt_rr_state = RR_IDLE;
    end else begin
      case (rr_state_ff)
        RR_IDLE: begin
          if (rr_s && !rr_d_ff) begin // RL23
            nxt_rr_state = rstart_s ? RR_HELD : RR_ARMED; // RL6
          end
        end
        RR_HELD, RR_ARMED: begin
          if (!rr_s) begin
            nxt_rr_state = RR_IDLE;
            rem_warn_clr = 1'b1; // RL23
            rem_sd_clr = (rr_state_ff == RR_ARMED) && !rstart_s; // RL6
          end else if (rstart_s) begin
            nxt_rr_state = RR_HELD; // remote start came back: disarm
          end
        end
        default: nxt_rr_state = RR_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rr_state_ff <= RR_IDLE;
    end else begin
      rr_state_ff <= nxt_rr_state;
    end
  end

  // ----------------------------------------------------------------
  // fault latches, one per table entry
  // ----------------------------------------------------------------
  localparam logic [383:0] CODE_TAB = `FA_CODE_TABLE; // RL12 RL13 RL14 RL15 RL16
  localparam logic [31:0] SD_MASK = `FA_SD_MASK; // RL18 RL19 RL21 RL22
  logic [31:0] eff_sd; // severity after customer configuration
  logic [31:0] lat_ff; // latched fault flags

  always_comb begin
    eff_sd = SD_MASK;
    eff_sd[`FA_CUST_LSB +: 3] = cust_sd_in; // RL17
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FA_NUM_FAULTS; gi++) begin : g_fault
      logic clr, nxt_lat;
      // a present condition always wins over any clear
      always_comb begin
        clr = 1'b0;
        if (!cond_s[gi]) begin
          if (!eff_sd[gi]) begin
            clr = panel_press || rem_warn_clr; // RL2 RL3
          end else begin
            clr = (panel_press && sel == SEL_OFF) // RL5
                  || (rem_sd_clr && gi != `FA_ESTOP_IDX); // RL6 RL7
          end
        end
        nxt_lat = cond_s[gi] | (lat_ff[gi] & ~clr); // RL4
      end
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          lat_ff[gi] <= 1'b0;
        end else begin
          lat_ff[gi] <= nxt_lat;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // editable customer messages
  // ----------------------------------------------------------------
  logic [127:0] user_msg_ff [3];
  logic [127:0] nxt_user_msg [3];

  // slot 3 does not exist and writes to it are dropped
  always_comb begin
    for (int s = 0; s < 3; s++) begin
      nxt_user_msg[s] = user_msg_ff[s];
      if (msg_wr_in && msg_slot_in == 2'(s)) begin
        nxt_user_msg[s][8*(15-msg_pos_in) +: 8] = msg_char_in; // RL17
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_msg_ff[0] <= `FA_CUST0_TEXT;
      user_msg_ff[1] <= `FA_CUST1_TEXT;
      user_msg_ff[2] <= `FA_CUST2_TEXT;
    end else begin
      for (int s = 0; s < 3; s++) begin
        user_msg_ff[s] <= nxt_user_msg[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // message text and display selection
  // ----------------------------------------------------------------
  // fixed text of each entry, left justified and padded with spaces
  function automatic logic [127:0] msg_text(input logic [5:0] id);
    logic [127:0] t;
    case (id)
      6'h00: t = "EMERGENCY STOP";
      6'h01, 6'h02: t = "LOW OIL PRESSURE";
      6'h03: t = "LOW COOLANT TEMP";
      6'h04, 6'h05: t = "HIGH COOLANT TMP"; // seventeen characters do not fit a line
      6'h06: t = "COOLANT SENDER";
      6'h07, 6'h08: t = "LOW COOLANT LVL";
      6'h09: t = "MAG PICKUP";
      6'h0A: t = "FAIL TO CRANK";
      6'h0B: t = "OVERSPEED";
      6'h0C: t = "LOW DC VOLTAGE";
      6'h0D: t = "HIGH DC VOLTAGE";
      6'h0E: t = "WEAK BATTERY";
      6'h0F: t = "LOW FUEL - DAY";
      6'h10: t = "LOW FUEL";
      6'h11, 6'h12, 6'h13: t = "EEPROM ERROR";
      6'h14: t = "RACK POSITION";
      6'h18: t = "HIGH AC VOLTAGE";
      6'h19: t = "LOW AC VOLTAGE";
      6'h1A: t = "UNDER FREQUENCY";
      6'h1B, 6'h1C: t = "OVERCURRENT";
      6'h1D: t = "SHORT CIRCUIT";
      6'h1E: t = "OVERLOAD";
      6'h1F: t = "REVERSE POWER";
      `FA_NOTE_SETUP_ID: t = "INVALID SETUP"; // RL20
      `FA_NOTE_CAL_ID: t = "INVALID CAL"; // RL20
      default: t = '0;
    endcase
    for (int k = 0; k < 16; k++) begin
      if (t[127:120] == 8'h00) begin
        t = {t[119:0], 8'h20};
      end
    end
    return t;
  endfunction

  disp_kind_t disp_kind_ff, nxt_kind;
  logic [127:0] nxt_line1, nxt_line2;
  logic [11:0] nxt_code;

  // lowest entry of each severity wins; any shutdown outranks warnings
  always_comb begin
    logic [5:0] sd_id, wn_id, id;
    logic sd_any, wn_any;
    id = '0;
    sd_id = '0;
    wn_id = '0;
    sd_any = 1'b0;
    wn_any = 1'b0;
    for (int i = `FA_NUM_FAULTS - 1; i >= 0; i--) begin
      if (lat_ff[i] && eff_sd[i]) begin
        sd_id = 6'(i);
        sd_any = 1'b1;
      end
      if (lat_ff[i] && !eff_sd[i]) begin
        wn_id = 6'(i);
        wn_any = 1'b1;
      end
    end
    nxt_kind = DISP_NONE;
    nxt_code = '0;
    if (sd_any) begin
      id = sd_id; // RL24
      nxt_kind = DISP_SHUTDOWN;
    end else if (wn_any) begin
      id = wn_id; // RL1
      nxt_kind = DISP_WARNING;
    end else if (setup_s || cal_s) begin
      id = setup_s ? `FA_NOTE_SETUP_ID : `FA_NOTE_CAL_ID; // RL20
      nxt_kind = DISP_NOTE;
    end
    if (nxt_kind == DISP_SHUTDOWN || nxt_kind == DISP_WARNING) begin
      nxt_code = CODE_TAB[12*id[4:0] +: 12];
    end
    nxt_line2 = msg_text(id);
    if (id >= 6'(`FA_CUST_LSB) && id < 6'(`FA_CUST_LSB + 3)) begin
      nxt_line2 = user_msg_ff[2'(id - 6'(`FA_CUST_LSB))]; // RL17
    end
    case (nxt_kind)
      DISP_SHUTDOWN: nxt_line1 = {"SHUTDOWN     ", 4'h3, nxt_code[11:8], 4'h3,
                                  nxt_code[7:4], 4'h3, nxt_code[3:0]};
      DISP_WARNING: nxt_line1 = {"WARNING      ", 4'h3, nxt_code[11:8], 4'h3,
                                 nxt_code[7:4], 4'h3, nxt_code[3:0]};
      default: nxt_line1 = {16{8'h20}}; // notes carry no code
    endcase
    if (nxt_kind == DISP_NONE) begin
      nxt_line2 = {16{8'h20}};
    end
  end

  // display registers; each line is sixteen ascii characters, left first
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      disp_kind_ff <= DISP_NONE;
      disp_code_out <= '0;
      disp_line1_out <= {16{8'h20}};
      disp_line2_out <= {16{8'h20}};
    end else begin
      disp_kind_ff <= nxt_kind;
      disp_code_out <= nxt_code;
      disp_line1_out <= nxt_line1; // RL11
      disp_line2_out <= nxt_line2; // RL11
    end
  end
  assign disp_valid_out = (disp_kind_ff != DISP_NONE);

  // ----------------------------------------------------------------
  // flash divider and lamps
  // ----------------------------------------------------------------
  logic [24:0] flash_cnt_ff, nxt_flash_cnt;
  logic flash_ff, nxt_flash;
  logic nxt_warn, nxt_sd, nxt_na, nxt_grant;

  // the divider runs free, so the lamp phase is not tied to switch changes
  always_comb begin
    nxt_flash_cnt = flash_cnt_ff + 25'h0000001;
    nxt_flash = flash_ff;
    if (flash_cnt_ff >= 25'(FLASH_HALF_CYC - 1)) begin
      nxt_flash_cnt = '0;
      nxt_flash = ~flash_ff;
    end
    nxt_warn = |(lat_ff & ~eff_sd); // RL1
    nxt_sd = |(lat_ff & eff_sd); // RL4 RL10
    nxt_na = (sel == SEL_OFF) && flash_ff; // RL9
    nxt_grant = standby_req_in && (lat_ff == '0); // RL8
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_cnt_ff <= '0;
      flash_ff <= 1'b0;
      warn_lamp_out <= 1'b0;
      sd_lamp_out <= 1'b0;
      not_auto_lamp_out <= 1'b0;
      standby_grant_out <= 1'b0;
    end else begin
      flash_cnt_ff <= nxt_flash_cnt;
      flash_ff <= nxt_flash;
      warn_lamp_out <= nxt_warn;
      sd_lamp_out <= nxt_sd;
      not_auto_lamp_out <= nxt_na;
      standby_grant_out <= nxt_grant;
    end
  end
  // stop and trip follow the shutdown lamp register exactly
  assign engine_stop_out = sd_lamp_out; // RL10
  assign breaker_trip_out = sd_lamp_out; // RL10

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_warn_lamp;
    (|(cond_s & ~eff_sd)) && $stable(eff_sd) |-> ##2 warn_lamp_out;
  endproperty
  a_warn_lamp: assert property (p_warn_lamp) else $error("warning lamp not lit"); // RL1
  property p_panel_warn;
    panel_press && lat_ff[4] && !cond_s[4] && !eff_sd[4] |=> !lat_ff[4];
  endproperty
  a_panel_warn: assert property (p_panel_warn) else $error("warning kept after press"); // RL2
  property p_remote_warn;
    rem_warn_clr && lat_ff[3] && !cond_s[3] |=> !lat_ff[3];
  endproperty
  a_remote_warn: assert property (p_remote_warn) else $error("remote warn clear lost"); // RL3
  property p_sd_hold;
    !panel_press && !rem_sd_clr |=> ($past(lat_ff & eff_sd) & ~lat_ff) == '0;
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown dropped unasked"); // RL4
  property p_press_not_off;
    panel_press && sel != SEL_OFF && !rem_sd_clr
      |=> ($past(lat_ff & eff_sd) & ~lat_ff) == '0;
  endproperty
  a_press_not_off: assert property (p_press_not_off) else $error("press cleared sd"); // RL5
  property p_remote_sd;
    rem_sd_clr |-> sel == SEL_AUTO && !rstart_s && rr_d_ff && !rr_s;
  endproperty
  a_remote_sd: assert property (p_remote_sd) else $error("bad remote sd clear"); // RL6
  property p_estop;
    !(panel_press && sel == SEL_OFF) |=> !$fell(lat_ff[0]);
  endproperty
  a_estop: assert property (p_estop) else $error("estop cleared remotely"); // RL7
  property p_standby;
    standby_grant_out |-> $past(lat_ff) == '0;
  endproperty
  a_standby: assert property (p_standby) else $error("standby with faults"); // RL8
  property p_flash;
    $changed(flash_ff) |-> $past(flash_cnt_ff) == 25'(FLASH_HALF_CYC - 1);
  endproperty
  a_flash: assert property (p_flash) else $error("flash toggled off count"); // RL9
  property p_stop;
    |(lat_ff & eff_sd) |=> engine_stop_out && breaker_trip_out;
  endproperty
  a_stop: assert property (p_stop) else $error("shutdown did not stop"); // RL10
  property p_sd_first;
    |(lat_ff & eff_sd) |=> disp_kind_ff == DISP_SHUTDOWN;
  endproperty
  a_sd_first: assert property (p_sd_first) else $error("warning shown over sd"); // RL24
  property p_once;
    rem_warn_clr |=> !rem_warn_clr;
  endproperty
  a_once: assert property (p_once) else $error("double remote clear"); // RL23
  property p_note;
    disp_kind_ff == DISP_NOTE |-> disp_code_out == '0 && !warn_lamp_out && !sd_lamp_out;
  endproperty
  a_note: assert property (p_note) else $error("note carried code or lamp"); // RL20

  c_remote_sd: cover property (rem_sd_clr && lat_ff != '0);
  c_panel_off: cover property (panel_press && sel == SEL_OFF && sd_lamp_out);
  c_both: cover property (warn_lamp_out && sd_lamp_out);

endmodule

// File: src/fault_annunciator_regs.svh
// constants for the fault annunciator: table of codes, severities, timing
// assumes a 40 MHz system clock and fault index 0 being the emergency stop
`ifndef FAULT_ANNUNCIATOR_REGS_SVH
`define FAULT_ANNUNCIATOR_REGS_SVH

// ----------------------------------------------------------------
// fault table layout
// ----------------------------------------------------------------
`define FA_NUM_FAULTS 32
`define FA_ESTOP_IDX 0
`define FA_CUST_LSB 21
`define FA_NOTE_SETUP_ID 6'h20
`define FA_NOTE_CAL_ID 6'h21
// bcd codes, entry 31 first and entry 0 (emergency stop) last
`define FA_CODE_TABLE {12'h335, 12'h330, 12'h322, 12'h321, 12'h320, 12'h313, 12'h303, \
  12'h301, 12'h263, 12'h262, 12'h261, 12'h260, 12'h252, 12'h251, 12'h250, 12'h241, \
  12'h240, 12'h232, 12'h231, 12'h230, 12'h223, 12'h221, 12'h220, 12'h215, 12'h214, \
  12'h213, 12'h212, 12'h211, 12'h210, 12'h201, 12'h200, 12'h102}
// one bit per entry: set means shutdown severity
`define FA_SD_MASK 32'hB702_0F25
// default text of the three customer faults
`define FA_CUST0_TEXT "GROUND FAULT    "
`define FA_CUST1_TEXT "RUPTURE BASIN   "
`define FA_CUST2_TEXT "HIGH GEN TEMP   "

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FA_CLK_KHZ 40000
`define FA_FLASH_HALF_MS 500

`endif

// File: src/fault_annunciator_pkg.sv
// types shared by the fault annunciator
// assumes nothing beyond a systemverilog compiler
package fault_annunciator_pkg;
  // run/off/auto selector position
  typedef enum logic [1:0] {SEL_OFF, SEL_RUN, SEL_AUTO} selector_t;
  // what the display currently shows
  typedef enum logic [1:0] {DISP_NONE, DISP_SHUTDOWN, DISP_WARNING, DISP_NOTE} disp_kind_t;
  // remote reset cycle tracker
  typedef enum logic [1:0] {RR_IDLE, RR_HELD, RR_ARMED} rr_state_t;
endpackage

// File: test/panel_model.sv
// operator panel model: run/off/auto selector and an eye on the non-auto lamp
// assumes the bench gives a selector position and clears the flash count
`timescale 1ns/1ps

module panel_model
  import fault_annunciator_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire selector_t sel_in,
  input wire logic lamp_in,
  input wire logic clr_in,
  output logic sel_run_out,
  output logic sel_auto_out,
  output logic [7:0] rises_out
);
  // ----------------------------------------------------------------
  // selector contacts
  // ----------------------------------------------------------------
  // a real switch never closes both contacts, so neither is driven with the other
  assign sel_run_out = (sel_in == SEL_RUN);
  assign sel_auto_out = (sel_in == SEL_AUTO);

  // ----------------------------------------------------------------
  // lamp watcher
  // ----------------------------------------------------------------
  logic lamp_ff; // lamp level one edge back
  logic [7:0] rises_ff; // rising edges of the lamp seen so far
  logic [7:0] nxt_rises;

  // count lamp turn-ons so the bench can tell a flash from a steady lamp
  always_comb begin
    nxt_rises = rises_ff;
    if (clr_in) begin
      nxt_rises = 8'h00;
    end else if (lamp_in && !lamp_ff && rises_ff != 8'hFF) begin
      nxt_rises = rises_ff + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lamp_ff <= 1'b0;
      rises_ff <= 8'h00;
    end else begin
      lamp_ff <= lamp_in;
      rises_ff <= nxt_rises;
    end
  end

  assign rises_out = rises_ff;
endmodule

// File: test/test_fault_annunciator_reset_logic.sv
// self-checking bench of the fault annunciator and its reset paths
// assumes the design's two-flop input sync and a short flash parameter
`timescale 1ns/1ps

module test_fault_annunciator_reset_logic;
  import fault_annunciator_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk_in, reset_n_in, bad_setup_in, bad_cal_in, panel_reset_in;
  logic remote_reset_in, remote_start_in, sel_run_in, sel_auto_in;
  logic msg_wr_in, standby_req_in, clr_cnt;
  logic [31:0] cond_in;
  logic [2:0] cust_sd_in;
  logic [1:0] msg_slot_in;
  logic [3:0] msg_pos_in;
  logic [7:0] msg_char_in, rises, ch;
  logic warn_lamp_out, sd_lamp_out, not_auto_lamp_out, engine_stop_out;
  logic breaker_trip_out, standby_grant_out, disp_valid_out, sd;
  logic [11:0] disp_code_out;
  logic [127:0] disp_line1_out, disp_line2_out;
  selector_t sel;
  int err_total, comparisons, seed;
  // expected code of each condition entry, written out from the fault list
  localparam logic [11:0] codes [32] = '{12'h102, 12'h200, 12'h201, 12'h210, 12'h211,
    12'h212, 12'h213, 12'h214, 12'h215, 12'h220, 12'h221, 12'h223, 12'h230, 12'h231,
    12'h232, 12'h240, 12'h241, 12'h250, 12'h251, 12'h252, 12'h260, 12'h261, 12'h262,
    12'h263, 12'h301, 12'h303, 12'h313, 12'h320, 12'h321, 12'h322, 12'h330, 12'h335};
  localparam logic [31:0] sd_mask = 32'hB702_0F25; // fixed shutdown entries

  fault_annunciator_reset_logic #(.FLASH_HALF_CYC(8)) DUT (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .cond_in(cond_in), .bad_setup_in(bad_setup_in),
    .bad_cal_in(bad_cal_in), .panel_reset_in(panel_reset_in),
    .remote_reset_in(remote_reset_in), .remote_start_in(remote_start_in),
    .sel_run_in(sel_run_in), .sel_auto_in(sel_auto_in), .cust_sd_in(cust_sd_in),
    .msg_wr_in(msg_wr_in), .msg_slot_in(msg_slot_in), .msg_pos_in(msg_pos_in),
    .msg_char_in(msg_char_in), .standby_req_in(standby_req_in),
    .warn_lamp_out(warn_lamp_out), .sd_lamp_out(sd_lamp_out),
    .not_auto_lamp_out(not_auto_lamp_out), .engine_stop_out(engine_stop_out),
    .breaker_trip_out(breaker_trip_out), .standby_grant_out(standby_grant_out),
    .disp_valid_out(disp_valid_out), .disp_code_out(disp_code_out),
    .disp_line1_out(disp_line1_out), .disp_line2_out(disp_line2_out));

  panel_model panel (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sel_in(sel),
    .lamp_in(not_auto_lamp_out), .clr_in(clr_cnt), .sel_run_out(sel_run_in),
    .sel_auto_out(sel_auto_in), .rises_out(rises));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // top display line: severity word padded to 13 chars, then the code digits
  function automatic logic [127:0] line1_of(input logic [11:0] c, input logic s);
    line1_of = {s ? "SHUTDOWN     " : "WARNING      ", 8'h30 + {4'h0, c[11:8]},
      8'h30 + {4'h0, c[7:4]}, 8'h30 + {4'h0, c[3:0]}};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // press held long enough to pass the sync, then settle before looking
  task automatic press();
    panel_reset_in = 1'b1;
    tick(4);
    panel_reset_in = 1'b0;
    tick(6);
  endtask

  task automatic cycle_remote();
    remote_reset_in = 1'b1;
    tick(4);
    remote_reset_in = 1'b0;
    tick(6);
  endtask

  // raise a condition, let it latch, then take the cause away
  task automatic hit(input logic [31:0] c);
    cond_in = c;
    tick(6);
    cond_in = 32'h0;
    tick(6);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // the run needs some 1,000 cycles; twenty times that means a hang
  initial begin
    #(25 * 20000);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {cond_in, bad_setup_in, bad_cal_in, panel_reset_in, remote_reset_in} = '0;
    {remote_start_in, msg_wr_in, msg_slot_in, msg_pos_in, msg_char_in} = '0;
    {cust_sd_in, clr_cnt} = '0;
    standby_req_in = 1'b1;
    sel = SEL_OFF;
    err_total = 0;
    comparisons = 0;
    seed = 35;
    reset_n_in = 1'b0;
    tick(10);
    reset_n_in = 1'b1;
    tick(2);
    // every entry of the table, customer severities drawn at random
    for (int i = 0; i < 32; i++) begin
      cust_sd_in = 3'($random(seed));
      sd = (i >= 21 && i <= 23) ? cust_sd_in[i - 21] : sd_mask[i];
      cond_in = 32'h1 << i;
      tick(6);
      chk(disp_code_out, codes[i]);
      chk(disp_line1_out, line1_of(codes[i], sd));
      if (i == 2) chk(disp_line2_out, "LOW OIL PRESSURE");
      chk({sd_lamp_out, engine_stop_out, breaker_trip_out, warn_lamp_out}, {sd, sd, sd, !sd});
      cond_in = 32'h0;
      tick(6);
      chk({sd_lamp_out, warn_lamp_out, standby_grant_out}, {sd, !sd, 1'b0});
      press();
      chk({sd_lamp_out, warn_lamp_out, standby_grant_out}, 3'h1);
    end
    $display("test table done");
    // run: shutdown ahead of warning, press clears only the warning
    sel = SEL_RUN;
    cond_in = 32'h22;
    tick(6);
    chk(disp_code_out, 12'h212);
    cond_in = 32'h0;
    tick(6);
    press();
    chk({sd_lamp_out, warn_lamp_out}, 2'h2);
    cycle_remote();
    chk(sd_lamp_out, 1'b1);
    // auto: remote start must go first, clear lands only after the release
    sel = SEL_AUTO;
    remote_start_in = 1'b1;
    cycle_remote();
    chk(sd_lamp_out, 1'b1);
    remote_start_in = 1'b0;
    tick(4);
    remote_reset_in = 1'b1;
    tick(6);
    chk(sd_lamp_out, 1'b1);
    remote_reset_in = 1'b0;
    tick(6);
    chk(sd_lamp_out, 1'b0);
    hit(32'h1000);
    cycle_remote();
    chk(warn_lamp_out, 1'b0);
    // emergency stop ignores the remote path and presses outside off
    hit(32'h1);
    cycle_remote();
    chk(sd_lamp_out, 1'b1);
    press();
    chk(sd_lamp_out, 1'b1);
    sel = SEL_OFF;
    press();
    chk(sd_lamp_out, 1'b0);
    $display("test reset paths done");
    // setup and calibration notes: text only
    bad_setup_in = 1'b1;
    tick(6);
    chk({disp_valid_out, warn_lamp_out, sd_lamp_out, disp_code_out}, 15'h4000);
    chk(disp_line2_out, "INVALID SETUP   ");
    bad_setup_in = 1'b0;
    bad_cal_in = 1'b1;
    tick(6);
    chk({disp_valid_out, warn_lamp_out, sd_lamp_out, disp_code_out}, 15'h4000);
    chk(disp_line2_out, "INVALID CAL     ");
    bad_cal_in = 1'b0;
    // non-auto lamp flashes in off and stays dark in auto
    clr_cnt = 1'b1;
    tick(1);
    clr_cnt = 1'b0;
    tick(64);
    chk(rises >= 8'h03, 1'b1);
    sel = SEL_AUTO;
    tick(4);
    clr_cnt = 1'b1;
    tick(1);
    clr_cnt = 1'b0;
    tick(64);
    chk({rises, not_auto_lamp_out}, 9'h0);
    $display("test notes and flash done");
    // edited customer text with configured shutdown severity
    ch = 8'h41 + 8'($random(seed) & 8'h0F);
    {msg_slot_in, msg_pos_in, msg_char_in, msg_wr_in} = {2'h0, 4'h0, ch, 1'b1};
    tick(1);
    msg_wr_in = 1'b0;
    cust_sd_in = 3'h1;
    sel = SEL_OFF;
    cond_in = 32'h0020_0000;
    tick(6);
    chk(disp_line2_out, {ch, "ROUND FAULT    "});
    chk(sd_lamp_out, 1'b1);
    cond_in = 32'h0;
    tick(6);
    press();
    chk(sd_lamp_out, 1'b0);
    $display("test message edit done");
    // mid-run reset: everything dark, customer text back to its default
    reset_n_in = 1'b0;
    tick(2);
    chk({sd_lamp_out, disp_valid_out, disp_line2_out}, {2'h0, {16{8'h20}}});
    reset_n_in = 1'b1;
    tick(2);
    cond_in = 32'h0020_0000;
    tick(6);
    chk({disp_code_out, disp_line2_out}, {12'h261, "GROUND FAULT    "});
    cond_in = 32'h0;
    $display("test reset defaults done");
    wrap_up();
  end
endmodule
